// File: logic/rwsp_core.sv
// Purpose: Wiper setting, shutdown, calibration enable and power-on preset.
// Assumes: Reset pin comes from outside and is synchronised here.
// Notes:   Commands arrive as writes to the command register over AXI4-Lite.
`timescale 1ns/10ps
// Contract
// - Command 9 with bit0 one enters shutdown.
// - Shutdown disconnects end terminal from wiper.
// - Commands still execute while shut down.
// - Command 9 with bit0 zero leaves shutdown.
// - Software or hardware reset clears shutdown.
// - Wiper code selects exactly one tap.
// - Calibration enabled after reset, control bit toggles.
// - Power-up loads midscale, then last stored value; rstn_i clears count_reg, so the load gives midscale.
// - Software or pin reset reloads last stored, else midscale.
// - Write enable resets zero, blocks wiper writes.
module rwsp_core #(
    parameter int CODE_W = rwsp_pkg::CODE_W
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rstn_i,
    input  wire logic                   reset_pin_n_i,
    input  wire logic [3:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [3:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic [CODE_W-1:0]           wiper_code_o,
    output logic [(2**CODE_W)-1:0]      tap_sel_o,
    output logic                        end_connect_o,
    output logic                        cal_enable_o
);
    localparam int TAPS = 2**CODE_W;
    localparam logic [CODE_W-1:0] MIDSCALE =
        {1'b1, {(CODE_W-1){1'b0}}};

    function automatic logic [TAPS-1:0] tap_of(input logic [CODE_W-1:0] c);
        tap_of = {{(TAPS-1){1'b0}}, 1'b1} << c;
    endfunction

    rwsp_pkg::rwsp_state_t st_reg, st_next;
    logic [CODE_W-1:0]   wiper_reg, wiper_next;
    logic [TAPS-1:0]     tap_reg, tap_next;
    logic                end_conn_reg, end_conn_next;
    logic [2:0]          ctrl_reg, ctrl_next;
    logic [5:0]          count_reg, count_next;
    logic [31:0]         cmd_reg, cmd_next;
    logic                aw_full_reg, aw_full_next;
    logic [3:0]          aw_addr_reg, aw_addr_next;
    logic                w_full_reg, w_full_next;
    logic [31:0]         w_data_reg, w_data_next;
    logic                awready_reg, awready_next;
    logic                wready_reg, wready_next;
    logic                bvalid_reg, bvalid_next;
    logic [1:0]          bresp_reg, bresp_next;
    logic                arready_reg, arready_next;
    logic                rvalid_reg, rvalid_next;
    logic [31:0]         rdata_reg, rdata_next;
    logic [1:0]          rresp_reg, rresp_next;
    logic                pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic                hw_evt;
    logic                exec;
    logic [3:0]          cmd;
    logic [CODE_W-1:0]   cmd_data;
    logic                mem_we;
    logic [5:0]          mem_raddr;
    logic [CODE_W-1:0]   mem_rdata;

    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    // Only a falling edge of the reset pin counts, so a pin tied high is idle.
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_s3_reg <= 1'b1;
        end else begin
            pin_s1_reg <= reset_pin_n_i;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end
    assign hw_evt = pin_s3_reg & ~pin_s2_reg;

    assign exec = aw_full_reg & w_full_reg & ~bvalid_reg &
                  (st_reg == rwsp_pkg::ST_RUN) &
                  (aw_addr_reg == rwsp_pkg::OFF_CMD);
    assign cmd = w_data_reg[rwsp_pkg::CMD_LSB +: 4];
    assign cmd_data = w_data_reg[CODE_W-1:0];
    assign mem_we = exec & ~hw_evt & (cmd == rwsp_pkg::CMD_STORE) &
                    ctrl_reg[rwsp_pkg::CTRL_FUSE] &
                    (count_reg < 6'(rwsp_pkg::STORE_DEPTH));
    assign mem_raddr = (count_reg == 6'h0) ? 6'h0 : count_reg - 6'h1;

    rwsp_store_mem #(
        .DEPTH (rwsp_pkg::STORE_DEPTH),
        .AW    (rwsp_pkg::STORE_AW),
        .DW    (CODE_W)
    ) u_store (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .we_i      (mem_we),
        .waddr_i   (count_reg),
        .wdata_i   (wiper_reg),
        .raddr_i   (mem_raddr),
        .rdata_o   (mem_rdata)
    );

    always_comb begin
        logic fire;
        fire = 1'b0;
        st_next       = st_reg;
        wiper_next    = wiper_reg;
        end_conn_next = end_conn_reg;
        ctrl_next     = ctrl_reg;
        count_next    = count_reg;
        cmd_next      = cmd_reg;
        aw_full_next  = aw_full_reg;
        aw_addr_next  = aw_addr_reg;
        w_full_next   = w_full_reg;
        w_data_next   = w_data_reg;
        bvalid_next   = bvalid_reg;
        bresp_next    = bresp_reg;
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_full_next = 1'b1;
            for (int i = 0; i < 4; i++) begin
                w_data_next[8*i +: 8] = s_axi_wstrb[i] ?
                                        s_axi_wdata[8*i +: 8] : 8'h00;
            end
        end
        fire = aw_full_reg & w_full_reg & ~bvalid_reg &
               (st_reg == rwsp_pkg::ST_RUN);
        if (fire) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (aw_addr_reg == rwsp_pkg::OFF_CMD) ?
                           rwsp_pkg::RESP_OKAY : rwsp_pkg::RESP_SLVERR;
        end
        unique case (st_reg)
            rwsp_pkg::ST_MID: begin
                st_next = rwsp_pkg::ST_READ;
            end
            rwsp_pkg::ST_READ: begin
                st_next = rwsp_pkg::ST_LOAD;
            end
            rwsp_pkg::ST_LOAD: begin
                wiper_next = (count_reg == 6'h0) ?
                             MIDSCALE : mem_rdata;
                st_next    = rwsp_pkg::ST_RUN;
            end
            rwsp_pkg::ST_RUN: begin
                if (exec) begin
                    cmd_next = w_data_reg;
                    unique case (cmd)
                        rwsp_pkg::CMD_WIPER_WR: begin
                            if (ctrl_reg[rwsp_pkg::CTRL_WE]) begin
                                wiper_next = cmd_data;
                            end
                        end
                        rwsp_pkg::CMD_STORE: begin
                            if (mem_we) begin
                                count_next = count_reg + 6'h1;
                            end
                        end
                        rwsp_pkg::CMD_SOFT_RST: begin
                            end_conn_next = 1'b1;
                            ctrl_next     = rwsp_pkg::CTRL_RESET;
                            st_next       = rwsp_pkg::ST_READ;
                        end
                        rwsp_pkg::CMD_CTRL_WR: begin
                            ctrl_next = cmd_data[2:0];
                        end
                        rwsp_pkg::CMD_SHUTDOWN: begin
                            end_conn_next = ~cmd_data[0];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase
        // The pin pulse wins over a command taken in the same cycle.
        if (hw_evt) begin
            end_conn_next = 1'b1;
            ctrl_next     = rwsp_pkg::CTRL_RESET;
            st_next       = rwsp_pkg::ST_READ;
            count_next    = count_reg;
        end
        tap_next     = tap_of(wiper_next);
        awready_next = ~aw_full_next;
        wready_next  = ~w_full_next;
    end

    always_comb begin
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next  = 1'b0;
            arready_next = 1'b1;
        end
        if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next  = 1'b1;
            rresp_next   = rwsp_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                rwsp_pkg::OFF_CMD:    rdata_next = cmd_reg;
                rwsp_pkg::OFF_STATUS: rdata_next =
                    32'({count_reg, 4'h0, ~end_conn_reg, ctrl_reg});
                rwsp_pkg::OFF_WIPER:  rdata_next = 32'(wiper_reg);
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = rwsp_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            st_reg       <= rwsp_pkg::ST_MID;
            wiper_reg    <= MIDSCALE;
            tap_reg      <= tap_of(MIDSCALE);
            end_conn_reg <= 1'b1;
            ctrl_reg     <= rwsp_pkg::CTRL_RESET;
            count_reg    <= 6'h0;
            cmd_reg      <= 32'h0000_0000;
            aw_full_reg  <= 1'b0;
            aw_addr_reg  <= 4'h0;
            w_full_reg   <= 1'b0;
            w_data_reg   <= 32'h0000_0000;
            awready_reg  <= 1'b0;
            wready_reg   <= 1'b0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= 2'h0;
            arready_reg  <= 1'b0;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
            rresp_reg    <= 2'h0;
        end else begin
            st_reg       <= st_next;
            wiper_reg    <= wiper_next;
            tap_reg      <= tap_next;
            end_conn_reg <= end_conn_next;
            ctrl_reg     <= ctrl_next;
            count_reg    <= count_next;
            cmd_reg      <= cmd_next;
            aw_full_reg  <= aw_full_next;
            aw_addr_reg  <= aw_addr_next;
            w_full_reg   <= w_full_next;
            w_data_reg   <= w_data_next;
            awready_reg  <= awready_next;
            wready_reg   <= wready_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            arready_reg  <= (st_reg == rwsp_pkg::ST_MID) ? 1'b1 : arready_next;
            rvalid_reg   <= rvalid_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign wiper_code_o  = wiper_reg;
    assign tap_sel_o     = tap_reg;
    assign end_connect_o = end_conn_reg;
    assign cal_enable_o  = ctrl_reg[rwsp_pkg::CTRL_CAL];

    sequence s_cmd(logic [3:0] c);
        exec && !hw_evt && cmd == c;
    endsequence
    sequence s_preset;
        st_reg == rwsp_pkg::ST_MID && wiper_reg == MIDSCALE;
    endsequence

    a_shut_enter: assert property (
        s_cmd(rwsp_pkg::CMD_SHUTDOWN) and cmd_data[0] |=> !end_connect_o)
        else $error("Shutdown command did not disconnect the end terminal.");
    a_shut_hold: assert property (
        !end_conn_reg && !exec && !hw_evt |=> !end_connect_o)
        else $error("End terminal reconnected without a command or reset.");
    a_cmd_in_shut: assert property (
        s_cmd(rwsp_pkg::CMD_WIPER_WR) and !end_conn_reg
        and ctrl_reg[rwsp_pkg::CTRL_WE] |=> wiper_reg == $past(cmd_data))
        else $error("Wiper write was lost while shut down.");
    a_shut_leave: assert property (
        s_cmd(rwsp_pkg::CMD_SHUTDOWN) and !cmd_data[0] |=> end_connect_o)
        else $error("Shutdown clear did not reconnect the end terminal.");
    a_rst_reconn: assert property (
        hw_evt or s_cmd(rwsp_pkg::CMD_SOFT_RST) |=> end_connect_o
        ##2 st_reg == rwsp_pkg::ST_RUN)
        else $error("Reset did not clear shutdown and reload the wiper.");
    a_tap_onehot: assert property (
        $onehot(tap_sel_o) && tap_sel_o[wiper_code_o])
        else $error("Tap select does not match the wiper code.");
    a_cal_default: assert property (
        s_preset |-> cal_enable_o && !ctrl_reg[rwsp_pkg::CTRL_WE])
        else $error("Calibration not enabled after reset.");
    a_cal_write: assert property (
        s_cmd(rwsp_pkg::CMD_CTRL_WR) |=> cal_enable_o == $past(cmd_data[2]))
        else $error("Calibration bit did not follow the control write.");
    a_pwrup_seq: assert property (
        s_preset |=> st_reg == rwsp_pkg::ST_READ
        ##1 st_reg == rwsp_pkg::ST_LOAD ##1 st_reg == rwsp_pkg::ST_RUN)
        else $error("Power-up preset sequence out of order.");
    a_reload_mid: assert property (
        st_reg == rwsp_pkg::ST_LOAD && count_reg == 6'h0 && !hw_evt
        |=> wiper_code_o == MIDSCALE)
        else $error("Empty store did not give midscale.");
    a_reload_store: assert property (
        st_reg == rwsp_pkg::ST_LOAD && count_reg != 6'h0
        |=> wiper_code_o == $past(mem_rdata))
        else $error("Reload did not take the last stored value.");
    a_we_block: assert property (
        s_cmd(rwsp_pkg::CMD_WIPER_WR) and !ctrl_reg[rwsp_pkg::CTRL_WE]
        |=> $stable(wiper_code_o))
        else $error("Wiper changed while writes were disabled.");
endmodule

// File: logic/rwsp_pkg.sv
// Purpose: Shared constants for the rheostat wiper, shutdown and preset block.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes:   Each register takes one aligned word.
package rwsp_pkg;
    localparam int          CODE_W       = 10;
    localparam int          STORE_DEPTH  = 50;
    localparam int          STORE_AW     = 6;
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  OFF_CMD      = 4'h0;
    localparam logic [3:0]  OFF_STATUS   = 4'h4;
    localparam logic [3:0]  OFF_WIPER    = 4'h8;
    localparam int          CMD_LSB      = 10;
    localparam logic [3:0]  CMD_WIPER_WR = 4'h1;
    localparam logic [3:0]  CMD_STORE    = 4'h3;
    localparam logic [3:0]  CMD_SOFT_RST = 4'h4;
    localparam logic [3:0]  CMD_CTRL_WR  = 4'h7;
    localparam logic [3:0]  CMD_SHUTDOWN = 4'h9;
    localparam int          CTRL_FUSE    = 0;
    localparam int          CTRL_WE      = 1;
    localparam int          CTRL_CAL     = 2;
    localparam logic [2:0]  CTRL_RESET   = 3'h4;
    localparam int          STAT_SHUT    = 3;
    localparam int          STAT_CNT_LSB = 8;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    typedef enum logic [3:0] {
        ST_MID  = 4'h1,
        ST_READ = 4'h2,
        ST_LOAD = 4'h4,
        ST_RUN  = 4'h8
    } rwsp_state_t;
endpackage

// File: logic/rwsp_store_mem.sv
// Purpose: One-time wiper store, a small word memory with registered read.
// Assumes: One write port and one read port on the system clock.
// Notes:   Contents are not cleared by reset, as a fused store would keep them.
`timescale 1ns/10ps
module rwsp_store_mem #(
    parameter int DEPTH  = 50,
    parameter int AW     = 6,
    parameter int DW     = 10
) (
    input  wire logic          clk_sys_i,
    input  wire logic          rstn_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_reg;

    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= mem[raddr_i];
        end
    end

    assign rdata_o = rdata_reg;
endmodule

// File: testbench/rwsp_host_model.sv
// Purpose: Host model that sends commands over AXI4-Lite and drives the reset pin.
// Assumes: The slave answers every request; the bench watchdog cuts a hang.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/10ps
module rwsp_host_model (
    input  wire logic        clk_sys_i,
    output logic             reset_pin_n_o,
    output logic [3:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [3:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        reset_pin_n_o = 1'b1;
        s_axi_awaddr  = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 4'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
    end

    task automatic write_word(input logic [3:0] addr, input logic [31:0] data,
                              output logic [1:0] resp);
        logic aw_open;
        logic w_open;
        logic done;
        aw_open = 1'b1;
        w_open  = 1'b1;
        done    = 1'b0;
        @(posedge clk_sys_i);
        s_axi_awaddr  <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= data;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!done) begin
            @(posedge clk_sys_i);
            if (aw_open && s_axi_awready) begin
                aw_open = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~addr;
            end
            if (w_open && s_axi_wready) begin
                w_open = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~data;
            end
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                done = 1'b1;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    task automatic read_word(input logic [3:0] addr, output logic [31:0] data,
                             output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge clk_sys_i);
        s_axi_araddr  <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!done) begin
            @(posedge clk_sys_i);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~addr;
            end
            if (s_axi_rvalid) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                done = 1'b1;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    // The data field carries the mode in its lowest bit only.
    task automatic shutdown(input logic on, output logic [1:0] resp);
        write_word(rwsp_pkg::OFF_CMD,
                   {18'h0, rwsp_pkg::CMD_SHUTDOWN, 9'h0, on}, resp);
    endtask

    task automatic pulse_reset_pin(input int low_cycles);
        @(posedge clk_sys_i);
        reset_pin_n_o <= 1'b0;
        repeat (low_cycles) @(posedge clk_sys_i);
        reset_pin_n_o <= 1'b1;
    endtask
endmodule

// File: testbench/tb.sv
// Purpose: Self-checking bench for the wiper, shutdown and preset block.
// Assumes: Default ten-bit code width.
// Notes:   Each scenario drives the block and judges the outcome itself.
`timescale 1ns/10ps
module tb;
    localparam int CW = rwsp_pkg::CODE_W;
    localparam int VW = 2**CW;
    localparam logic [CW-1:0] MID = 10'h200;
    logic clk_sys_i, rstn_i, reset_pin_n, s_axi_awvalid, s_axi_awready;
    logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [CW-1:0] wiper_code;
    logic [VW-1:0] tap_sel;
    logic end_connect, cal_enable;
    int err_count, comparisons;

    rwsp_core #(.CODE_W(CW)) dut_u (.clk_sys_i, .rstn_i,
        .reset_pin_n_i(reset_pin_n), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .wiper_code_o(wiper_code), .tap_sel_o(tap_sel),
        .end_connect_o(end_connect), .cal_enable_o(cal_enable));
    rwsp_host_model host_u (.clk_sys_i, .reset_pin_n_o(reset_pin_n),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [VW-1:0] seen, input logic [VW-1:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask

    function automatic logic [31:0] cmd(input logic [3:0] c, input logic [9:0] d);
        return {18'h0, c, d};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        host_u.write_word(a, d, resp);
        check(resp, r, "write response");
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
        logic [31:0] d;
        host_u.read_word(a, d, resp);
        check(resp, r, "read response");
        check(d, e, "read data");
    endtask

    // Outputs are looked at on the falling edge, well away from any update.
    task automatic expect_out(input logic [CW-1:0] code, input logic conn,
                              input logic cal);
        logic [VW-1:0] one;
        one = 1;
        @(negedge clk_sys_i);
        check(wiper_code, code, "wiper code");
        check(tap_sel, one << code, "tap select");
        check(end_connect, conn, "end connect");
        check(cal_enable, cal, "calibration enable");
    endtask

    task automatic t_power_up();
        expect_out(MID, 1'b1, 1'b1);
        rd(rwsp_pkg::OFF_STATUS, 32'h4, rwsp_pkg::RESP_OKAY);
        rd(rwsp_pkg::OFF_WIPER, 32'h200, rwsp_pkg::RESP_OKAY);
    endtask

    task automatic t_protect();
        logic [9:0] codes [3] = '{10'h000, 10'h3ff, 10'h155};
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_WIPER_WR, 10'h155), 2'h0);
        expect_out(MID, 1'b1, 1'b1);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_CTRL_WR, 10'h006), 2'h0);
        foreach (codes[i]) begin
            wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_WIPER_WR, codes[i]), 2'h0);
            expect_out(codes[i], 1'b1, 1'b1);
        end
    endtask

    task automatic t_shutdown();
        host_u.shutdown(1'b1, resp);
        check(resp, rwsp_pkg::RESP_OKAY, "shutdown response");
        expect_out(10'h155, 1'b0, 1'b1);
        rd(rwsp_pkg::OFF_STATUS, 32'he, rwsp_pkg::RESP_OKAY);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_WIPER_WR, 10'h0aa), 2'h0);
        expect_out(10'h0aa, 1'b0, 1'b1);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_CTRL_WR, 10'h002), 2'h0);
        expect_out(10'h0aa, 1'b0, 1'b0);
        host_u.shutdown(1'b0, resp);
        check(resp, rwsp_pkg::RESP_OKAY, "shutdown response");
        expect_out(10'h0aa, 1'b1, 1'b0);
    endtask

    task automatic t_soft_reset();
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_CTRL_WR, 10'h007), 2'h0);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_WIPER_WR, 10'h123), 2'h0);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_STORE, 10'h000), 2'h0);
        rd(rwsp_pkg::OFF_STATUS, 32'h107, rwsp_pkg::RESP_OKAY);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_WIPER_WR, 10'h321), 2'h0);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_CTRL_WR, 10'h003), 2'h0);
        host_u.shutdown(1'b1, resp);
        expect_out(10'h321, 1'b0, 1'b0);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_SOFT_RST, 10'h000), 2'h0);
        rd(rwsp_pkg::OFF_STATUS, 32'h104, rwsp_pkg::RESP_OKAY);
        expect_out(10'h123, 1'b1, 1'b1);
    endtask

    task automatic t_pin_reset();
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_CTRL_WR, 10'h002), 2'h0);
        wr(rwsp_pkg::OFF_CMD, cmd(rwsp_pkg::CMD_WIPER_WR, 10'h0f0), 2'h0);
        host_u.shutdown(1'b1, resp);
        expect_out(10'h0f0, 1'b0, 1'b0);
        host_u.pulse_reset_pin(4);
        repeat (8) @(posedge clk_sys_i);
        expect_out(10'h123, 1'b1, 1'b1);
        rd(rwsp_pkg::OFF_STATUS, 32'h104, rwsp_pkg::RESP_OKAY);
    endtask

    task automatic t_refused();
        wr(rwsp_pkg::OFF_WIPER, 32'h3, rwsp_pkg::RESP_SLVERR);
        rd(4'hc, 32'h0, rwsp_pkg::RESP_SLVERR);
        expect_out(10'h123, 1'b1, 1'b1);
    endtask

    task automatic complete_run();
        $display("Checks made: %0d, mismatches: %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The longest run needs a few hundred cycles; this leaves wide margin.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        complete_run();
    end

    initial begin
        err_count = 0;
        comparisons = 0;
        rstn_i = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_power_up();
        t_protect();
        t_shutdown();
        t_soft_reset();
        t_pin_reset();
        t_refused();
        complete_run();
    end
endmodule
